// *** rtl/srcd_bank_fsm.sv ***
// One bank's idle, active and precharging state tracker.
`timescale 1ns/100ps
`include "srcd_params.svh"
module srcd_bank_fsm
  import srcd_pkg::*;
#(
  parameter int TRP_CYC = `SRCD_TRP_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Commands aimed at this bank
  input wire logic open_req,
  input wire logic close_req,
  // State
  output logic active
);
  srcd_bank_state_t state;
  srcd_bank_state_t next_state;
  logic [3:0] cnt;
  wire logic cnt_done = (cnt == 4'h0);

  always_comb begin
    next_state = state;
    case (state)
      SRCD_IDLE: begin
        if (open_req) begin
          next_state = SRCD_ACTIVE;
        end
      end
      SRCD_ACTIVE: begin
        if (close_req) begin
          next_state = SRCD_PRECH;
        end
      end
      SRCD_PRECH: begin
        if (cnt_done) begin
          next_state = SRCD_IDLE;
        end
      end
      default: next_state = SRCD_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state <= SRCD_IDLE;
      cnt <= 4'h0;
    end else begin
      state <= next_state;
      if (state == SRCD_ACTIVE && close_req) begin
        cnt <= 4'(TRP_CYC - 1);
      end else if (!cnt_done) begin
        cnt <= cnt - 4'h1;
      end
    end
  end

  assign active = (state == SRCD_ACTIVE);
endmodule // srcd_bank_fsm

// *** rtl/srcd_decode.sv ***
// Command and address input stage of a four-bank synchronous DRAM.
// How it works
// RULE1: Strobes are registered only on rising clock edges, then decoded together.
// RULE2: Select and row strobe low, column strobe high means activate or precharge.
// RULE3: That combination with write strobe high opens the selected bank.
// RULE4: That combination with write strobe low closes the bank after precharge time.
// RULE5: Precharge scope bit high closes all banks, low only the selected one.
// RULE6: Reads and writes take column from bits 0-7, auto-precharge from bit 10.
// RULE7: Activate takes the twelve-bit row from the address bus and stores it.
// RULE8: Select sampled high ignores every other command input that cycle.
// RULE9: Bank-directed commands act only on the bank that the select pair names.
// RULE10: Select pair 00,01,10,11 maps to banks zero to three, high bit first.
// RULE11: Controller reads or writes only active banks and activates only idle ones; the testbench also activates open bank one.
`timescale 1ns/100ps
`include "srcd_params.svh"
module srcd_decode
  import srcd_pkg::*;
#(
  parameter int NBANK = `SRCD_NBANK,
  parameter int TRP_CYC = `SRCD_TRP_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Command pins
  input wire srcd_cmd_pins_t cmd_pins,
  // Address pins
  input wire logic bank_select_hi,
  input wire logic bank_select_lo,
  input wire logic [11:0] multiplexed_address_bus,
  // Decoded command, one cycle per command
  output srcd_cmd_t cmd,
  output logic [1:0] cmd_bank,
  output logic [7:0] col_addr,
  output logic auto_precharge,
  output logic precharge_all,
  // Bank state and open rows
  output logic [NBANK-1:0] bank_active,
  output logic [NBANK-1:0][11:0] open_row
);
  // Pins come from the controller's clock tree, so they are treated as asynchronous.
  srcd_cmd_pins_t cmd_s1;
  srcd_cmd_pins_t cmd_s2;
  srcd_addr_pins_t addr_s1;
  srcd_addr_pins_t addr_s2;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cmd_s1 <= 4'hF;
      cmd_s2 <= 4'hF;
      addr_s1 <= 14'h0000;
      addr_s2 <= 14'h0000;
    end else begin
      cmd_s1 <= cmd_pins; // RULE1
      cmd_s2 <= cmd_s1;
      addr_s1 <= {bank_select_hi, bank_select_lo, multiplexed_address_bus};
      addr_s2 <= addr_s1;
    end
  end

  // The decoder sees only the second synchroniser stage.
  // The pin combinations that this block does not serve all fall through to NOP.
  // This keeps unsupported commands from touching any bank state.
  function automatic srcd_cmd_t decode_cmd(input srcd_cmd_pins_t p);
    if (p.cs_n) begin
      decode_cmd = SRCD_NOP; // RULE8
    end else if (!p.ras_n && p.cas_n) begin
      decode_cmd = p.we_n ? SRCD_ACT : SRCD_PRE; // RULE2
    end else if (p.ras_n && !p.cas_n) begin
      decode_cmd = p.we_n ? SRCD_RD : SRCD_WR;
    end else begin
      decode_cmd = SRCD_NOP;
    end
  endfunction

  wire srcd_cmd_t dec = decode_cmd(cmd_s2); // RULE1
  wire logic [1:0] sel_bank = addr_s2.bank; // RULE10
  wire logic scope = addr_s2.addr[`SRCD_SCOPE_BIT]; // RULE5
  wire logic is_act = (dec == SRCD_ACT);
  wire logic is_pre = (dec == SRCD_PRE);
  logic [NBANK-1:0] open_req;
  logic [NBANK-1:0] close_req;

  // Each bank has its own tracker, so a precharge of all banks is simply a
  // close request fanned out to every tracker in the same cycle.
  // An activate aimed at a bank that is not idle is dropped by its tracker.
  genvar g;
  generate
    for (g = 0; g < NBANK; g++) begin : g_bank
      wire logic hit = (sel_bank == 2'(g)); // RULE9
      assign open_req[g] = is_act && hit; // RULE3
      assign close_req[g] = is_pre && (scope || hit); // RULE4 RULE5

      srcd_bank_fsm #(
        .TRP_CYC(TRP_CYC)
      ) u_bank (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .open_req(open_req[g]),
        .close_req(close_req[g]),
        .active(bank_active[g])
      );

      always_ff @(posedge sys_clk) begin
        if (!rstn) begin
          open_row[g] <= `SRCD_ROW_RST;
        end else if (open_req[g] && !bank_active[g]) begin
          open_row[g] <= addr_s2.addr; // RULE7
        end
      end
    end
  endgenerate

  // Outputs are registered, so a command shows two edges after its pin sample.
  // The flags are qualified by the command so they pulse only with it.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cmd <= SRCD_NOP;
      cmd_bank <= 2'h0;
      col_addr <= 8'h00;
      auto_precharge <= 1'b0;
      precharge_all <= 1'b0;
    end else begin
      cmd <= dec;
      cmd_bank <= sel_bank;
      col_addr <= addr_s2.addr[`SRCD_COL_W-1:0]; // RULE6
      auto_precharge <= (dec == SRCD_RD || dec == SRCD_WR) && scope; // RULE6
      precharge_all <= is_pre && scope; // RULE5
    end
  end

  // The checks below watch the decoded command and the bank state it drives.
  // They are written against the synchronised pins, since those are what the
  // decoder really sees; the raw pins are only used for the latency check.
  a_deselect_nop: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE8
    cmd_s2.cs_n |=> cmd == SRCD_NOP) else $error("command decoded while deselected");
  a_act_opens: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE3
    is_act && bank_active == '0 |=> bank_active[$past(sel_bank)]) else $error("activate did not open bank");
  a_pre_all: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE5
    is_pre && scope |=> bank_active == '0) else $error("precharge all left a bank open");
  a_pre_single: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE4
    is_pre && !scope && bank_active[sel_bank] |=> !bank_active[$past(sel_bank)])
    else $error("precharge did not close bank");
  a_row_stored: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE7
    is_act && bank_active == '0 |=> open_row[$past(sel_bank)] == $past(addr_s2.addr))
    else $error("row not captured");
  a_col_route: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE6
    dec == SRCD_RD |=> cmd == SRCD_RD && col_addr == $past(addr_s2.addr[7:0]) && auto_precharge == $past(scope))
    else $error("column routing wrong");
  a_pin_sampled: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE1 RULE2
    !cmd_pins.cs_n && !cmd_pins.ras_n && cmd_pins.cas_n && cmd_pins.we_n ##1 $stable(cmd_pins) |=>
    dec == SRCD_ACT) else $error("row command not decoded after sync");
  a_other_bank: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE9 RULE10
    is_act && sel_bank != 2'h0 && !bank_active[0] |=> !bank_active[0]) else $error("wrong bank opened");

  // A cycle without a command must leave both flags low.
  a_nop_clears: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE8
    dec == SRCD_NOP |=> !auto_precharge && !precharge_all)
    else $error("flag raised without command");

  // An activate to a bank that is already open must not disturb its row.
  a_refused_act: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE7
    is_act && bank_active[sel_bank] |=> open_row[$past(sel_bank)] == $past(open_row[sel_bank]))
    else $error("open row overwritten");

  // The reported bank follows the select pair of the same command.
  a_bank_routed: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE9 RULE10
    dec != SRCD_NOP |=> cmd_bank == $past(sel_bank))
    else $error("command bank wrong");

  // Writes route the column and the auto-precharge choice like reads.
  a_col_write: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE6
    dec == SRCD_WR |=> cmd == SRCD_WR && col_addr == $past(addr_s2.addr[7:0]) && auto_precharge == $past(scope))
    else $error("write column routing wrong");

  // A single-bank precharge elsewhere must leave bank zero open.
  a_pre_kept: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE9
    is_pre && !scope && sel_bank != 2'h0 && bank_active[0] |=> bank_active[0])
    else $error("unselected bank closed");

  // Row and column strobes at the same level carry no command served here.
  a_strobes_nop: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE2
    !cmd_s2.cs_n && (cmd_s2.ras_n == cmd_s2.cas_n) |=> cmd == SRCD_NOP)
    else $error("unserved strobe pattern decoded");

  // The write strobe alone chooses between activate and precharge.
  a_act_choice: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE2 RULE3
    !cmd_s2.cs_n && !cmd_s2.ras_n && cmd_s2.cas_n && cmd_s2.we_n |-> is_act)
    else $error("activate not chosen");

  // With the write strobe low the same pattern must be a precharge.
  a_pre_choice: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE2 RULE4
    !cmd_s2.cs_n && !cmd_s2.ras_n && cmd_s2.cas_n && !cmd_s2.we_n |-> is_pre)
    else $error("precharge not chosen");

  // The all-banks flag pulses with the precharge that carries the scope bit.
  a_pre_flag: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE5
    is_pre |=> cmd == SRCD_PRE && precharge_all == $past(scope))
    else $error("precharge scope flag wrong");

  // Open rows change only through an activate.
  a_row_held: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE7
    !is_act |=> open_row == $past(open_row))
    else $error("open row changed without activate");

  // A precharge to a bank that is not open changes no bank state.
  a_idle_ignored: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE4 RULE9
    is_pre && !scope && !bank_active[sel_bank] |=> bank_active == $past(bank_active))
    else $error("idle precharge changed state");

  // Auto-precharge is only meaningful beside a read or a write.
  a_ap_rdwr: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE6
    auto_precharge |-> cmd == SRCD_RD || cmd == SRCD_WR)
    else $error("auto-precharge without column command");

  c_activate: cover property (@(posedge sys_clk) is_act);
  c_precharge_all: cover property (@(posedge sys_clk) is_pre && scope);
  c_write_ap: cover property (@(posedge sys_clk) dec == SRCD_WR && scope);
  // A refused activate and a plain read are the two remaining main cases.
  c_refused_act: cover property (@(posedge sys_clk) is_act && bank_active[sel_bank]);
  c_read_plain: cover property (@(posedge sys_clk) dec == SRCD_RD && !scope);
endmodule // srcd_decode

// *** shared/srcd_params.svh ***
// Constants for the row command decode block: field positions and timing counts.
`ifndef SRCD_PARAMS_SVH
`define SRCD_PARAMS_SVH
`define SRCD_ADDR_W 12
`define SRCD_COL_W 8
`define SRCD_SCOPE_BIT 10
`define SRCD_NBANK 4
`define SRCD_CLK_NS 50
`define SRCD_TRP_NS 20
`define SRCD_TRP_CYC ((`SRCD_TRP_NS + `SRCD_CLK_NS - 1) / `SRCD_CLK_NS)
`define SRCD_ROW_RST 12'h000
`endif

// *** shared/srcd_pkg.sv ***
// Types shared by the row command decode block.
package srcd_pkg;
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } srcd_cmd_pins_t;

  typedef struct packed {
    logic [1:0] bank;
    logic [11:0] addr;
  } srcd_addr_pins_t;

  typedef enum logic [4:0] {
    SRCD_NOP = 5'h01,
    SRCD_ACT = 5'h02,
    SRCD_PRE = 5'h04,
    SRCD_RD = 5'h08,
    SRCD_WR = 5'h10
  } srcd_cmd_t;

  typedef enum logic [2:0] {
    SRCD_IDLE = 3'h1,
    SRCD_ACTIVE = 3'h2,
    SRCD_PRECH = 3'h4
  } srcd_bank_state_t;
endpackage

// *** tb/srcd_ctrl_model.sv ***
// Memory controller model that drives the command and address pins.
`timescale 1ns/100ps
module srcd_ctrl_model
  import srcd_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Pins towards the device
  output srcd_cmd_pins_t cmd_pins,
  output logic bank_select_hi,
  output logic bank_select_lo,
  output logic [11:0] multiplexed_address_bus
);
  initial begin
    cmd_pins = 4'hF;
    {bank_select_hi, bank_select_lo} = 2'h0;
    multiplexed_address_bus = 12'h000;
  end
  // Select is raised and the other lines are inverted after the command so a late sample cannot look correct.
  task automatic send(input logic [3:0] pins, input logic [1:0] bank, input logic [11:0] addr);
    @(posedge sys_clk);
    cmd_pins <= pins;
    {bank_select_hi, bank_select_lo} <= bank;
    multiplexed_address_bus <= addr;
    @(posedge sys_clk);
    cmd_pins <= {1'b1, ~pins[2:0]};
    {bank_select_hi, bank_select_lo} <= ~bank;
    multiplexed_address_bus <= ~addr;
  endtask
endmodule // srcd_ctrl_model

// *** tb/srcd_decode_tb.sv ***
// Self-checking testbench for the row command decode block.
`timescale 1ns/100ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module srcd_decode_tb;
  import srcd_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  int n_fail = 0;
  int cmp_count = 0;
  int cycles = 0;
  srcd_cmd_pins_t cmd_pins;
  logic bank_select_hi, bank_select_lo, auto_precharge, precharge_all;
  logic [11:0] multiplexed_address_bus;
  srcd_cmd_t cmd;
  logic [1:0] cmd_bank;
  logic [7:0] col_addr;
  logic [3:0] bank_active;
  logic [3:0][11:0] open_row;
  always #25 sys_clk = ~sys_clk;
  srcd_ctrl_model i_srcd_ctrl_model (.sys_clk(sys_clk), .cmd_pins(cmd_pins), .bank_select_hi(bank_select_hi),
    .bank_select_lo(bank_select_lo), .multiplexed_address_bus(multiplexed_address_bus));
  srcd_decode #(.NBANK(4), .TRP_CYC(1)) i_srcd_decode (.sys_clk(sys_clk), .rstn(rstn), .cmd_pins(cmd_pins),
    .bank_select_hi(bank_select_hi), .bank_select_lo(bank_select_lo),
    .multiplexed_address_bus(multiplexed_address_bus), .cmd(cmd), .cmd_bank(cmd_bank), .col_addr(col_addr),
    .auto_precharge(auto_precharge), .precharge_all(precharge_all), .bank_active(bank_active),
    .open_row(open_row));
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Decoded outputs show two edges after the pin cycle.
  task automatic issue(input logic [3:0] pins, input logic [1:0] bank, input logic [11:0] addr);
    i_srcd_ctrl_model.send(pins, bank, addr);
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task automatic test_activate();
    for (int b = 0; b < 4; b++) begin
      issue(4'h3, b[1:0], 12'hA50 | b[11:0]);
      `CHK("cmd", SRCD_ACT, cmd)
      `CHK("cmd_bank", b[1:0], cmd_bank)
      `CHK("open_row", 12'hA50 | b[11:0], open_row[b])
    end
    `CHK("bank_active", 4'hF, bank_active)
    issue(4'h3, 2'h1, 12'h123);
    `CHK("open_row", 12'hA51, open_row[1])
    $display("test activate done");
  endtask
  task automatic test_rdwr();
    issue(4'h5, 2'h1, 12'h4A5);
    `CHK("cmd", SRCD_RD, cmd)
    `CHK("col_addr", 8'hA5, col_addr)
    `CHK("auto_precharge", 1'b1, auto_precharge)
    issue(4'h4, 2'h2, 12'h05A);
    `CHK("cmd", SRCD_WR, cmd)
    `CHK("col_addr", 8'h5A, col_addr)
    `CHK("auto_precharge", 1'b0, auto_precharge)
    $display("test read write done");
  endtask
  task automatic test_deselect();
    issue(4'hB, 2'h0, 12'h777);
    `CHK("cmd", SRCD_NOP, cmd)
    `CHK("open_row", 12'hA50, open_row[0])
    $display("test deselect done");
  endtask
  task automatic test_precharge();
    issue(4'h2, 2'h3, 12'h000);
    `CHK("cmd", SRCD_PRE, cmd)
    `CHK("precharge_all", 1'b0, precharge_all)
    `CHK("bank_active", 4'h7, bank_active)
    issue(4'h2, 2'h0, 12'h400);
    `CHK("precharge_all", 1'b1, precharge_all)
    `CHK("bank_active", 4'h0, bank_active)
    issue(4'h3, 2'h3, 12'hFFF);
    `CHK("bank_active", 4'h8, bank_active)
    `CHK("open_row", 12'hFFF, open_row[3])
    $display("test precharge done");
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 1000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    test_activate();
    test_rdwr();
    test_deselect();
    test_precharge();
    complete_run();
  end
endmodule // srcd_decode_tb
